// File: src/dram_strobe_regs.vh
// Timing constants for the strobe-driven dynamic RAM controller.
`ifndef DRAM_STROBE_REGS_VH
`define DRAM_STROBE_REGS_VH
// Clock period in picoseconds (125 MHz).
`define CLK_PERIOD_PS 8000
// Times in nanoseconds; least times and access times round up, refresh step rounds down.
`define ROW_ADDR_HOLD_NS 25
`define ROW_TO_COL_DELAY_NS 50
`define ACCESS_FROM_ROW_NS 250
`define ACCESS_FROM_COL_NS 165
`define PRECHARGE_NS 120
`define WRITE_PULSE_NS 75
`define ROW_ADDR_HOLD_CYC ((`ROW_ADDR_HOLD_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define ROW_TO_COL_CYC ((`ROW_TO_COL_DELAY_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define ACCESS_ROW_CYC ((`ACCESS_FROM_ROW_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define ACCESS_COL_CYC ((`ACCESS_FROM_COL_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define PRECHARGE_CYC ((`PRECHARGE_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
// Refresh interval: 2 ms spread over 128 rows, longest time rounds down.
`define REFRESH_PERIOD_MS 2
`define REFRESH_ROWS 128
`define REFRESH_STEP_CYC ((`REFRESH_PERIOD_MS*1000000000/`REFRESH_ROWS)/`CLK_PERIOD_PS)
`endif

// File: src/refresh_timer.v
// Refresh request timer and row counter.
`timescale 1ns/1ps
`include "dram_strobe_regs.vh"
module refresh_timer #(
   parameter STEP_CYC = `REFRESH_STEP_CYC,
   parameter ROW_W = 7
) (
   input wire mclk,
   input wire rst,
   input wire refresh_done,
   output reg refresh_due_reg,
   output reg [ROW_W-1:0] refresh_row_reg
);
   reg [15:0] tick_reg;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_reg <= 16'h0000;
         refresh_due_reg <= 1'b0;
         refresh_row_reg <= {ROW_W{1'b0}};
      end else begin
         if (tick_reg >= STEP_CYC[15:0] - 16'h0001) begin
            tick_reg <= 16'h0000;
         end else begin
            tick_reg <= tick_reg + 16'h0001;
         end
         // A new tick wins over the done strobe of the same cycle.
         if (tick_reg >= STEP_CYC[15:0] - 16'h0001) begin
            refresh_due_reg <= 1'b1;
         end else if (refresh_done) begin
            refresh_due_reg <= 1'b0;
         end
         if (refresh_done) begin
            refresh_row_reg <= refresh_row_reg + {{(ROW_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // refresh_timer

// File: src/dram_strobe_ctrl.v
// Host-side controller driving a multiplexed-address 16K x 1 dynamic RAM.
// Operation
// - Cell address is 14 bits, sent as two 7-bit halves on shared pins.
// - Hold row address its hold time, then switch to column before strobe.
// - Early write: data sampled at column strobe fall.
// - Delayed write: data sampled at write enable fall.
// - Reads keep write enable high while column strobe is low.
// - With only early writes, data in and out may share one line.
// - Only a device receiving both strobes reads or writes.
// - Page mode keeps row strobe low; up to 128 columns per page.
// - Wider pages drive row strobe to all and decode column strobe.
// - Refresh all 128 rows within every 2 ms.
// - Prefer row-strobe-only refresh cycles; they use less power.
`timescale 1ns/1ps
`include "dram_strobe_regs.vh"
module dram_strobe_ctrl #(
   parameter ADDR_W = 7,
   parameter BANKS = 2,
   parameter REFRESH_STEP = `REFRESH_STEP_CYC
) (
   input wire mclk,
   input wire rst,
   input wire req_valid,
   input wire req_write,
   input wire req_delayed,
   input wire req_page_last,
   input wire [$clog2(BANKS)-1:0] req_bank,
   input wire [2*ADDR_W-1:0] req_addr,
   input wire req_wdata,
   output wire req_ready,
   output reg rd_valid_reg,
   output reg rd_data_reg,
   output reg [ADDR_W-1:0] mem_addr_reg,
   output reg row_strobe_n_reg,
   output reg [BANKS-1:0] column_strobe_n_reg,
   output reg write_enable_n_reg,
   output reg write_data_in_reg,
   input wire read_data_out
);
   // ------------------------------------------------------------
   // States and timing
   // ------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ROW = 3'h1;
   localparam [2:0] S_COL = 3'h2;
   localparam [2:0] S_ACC = 3'h3;
   localparam [2:0] S_PAGE = 3'h4;
   localparam [2:0] S_PRE = 3'h5;
   localparam [2:0] S_REF = 3'h6;
   // Whole-cycle counts are cut to the width of the cycle counter.
   localparam integer HOLD_I = `ROW_ADDR_HOLD_CYC;
   localparam integer RCD_I = `ROW_TO_COL_CYC;
   localparam integer ACC_R_I = `ACCESS_ROW_CYC;
   localparam integer ACC_C_I = `ACCESS_COL_CYC;
   localparam integer PRE_I = `PRECHARGE_CYC;
   localparam integer WR_I = `WRITE_PULSE_CYC;
   localparam [7:0] HOLD_C = HOLD_I[7:0];
   localparam [7:0] RCD_C = RCD_I[7:0];
   localparam [7:0] ACC_R_C = ACC_R_I[7:0];
   localparam [7:0] ACC_C_C = ACC_C_I[7:0];
   localparam [7:0] PRE_C = PRE_I[7:0];
   localparam [7:0] WR_C = WR_I[7:0];
   reg [2:0] state_reg;
   reg [7:0] cnt_reg;
   reg write_reg;
   reg delayed_reg;
   reg last_reg;
   reg [$clog2(BANKS)-1:0] bank_reg;
   reg [ADDR_W-1:0] row_reg;
   reg [ADDR_W-1:0] col_reg;
   reg data_reg;
   reg page_open_reg;
   reg sync1_reg;
   reg sync2_reg;
   reg refresh_done;
   wire refresh_due;
   wire [ADDR_W-1:0] refresh_row;
   // Decode one column strobe line from the bank number.
   function [BANKS-1:0] col_sel_n;
      input [$clog2(BANKS)-1:0] b;
      begin
         col_sel_n = ~({{(BANKS-1){1'b0}}, 1'b1} << b);
      end
   endfunction
   // ------------------------------------------------------------
   // Refresh timer
   // ------------------------------------------------------------
   refresh_timer #(
      .STEP_CYC(REFRESH_STEP),
      .ROW_W(ADDR_W)
   ) u_refresh (
      .mclk(mclk),
      .rst(rst),
      .refresh_done(refresh_done),
      .refresh_due_reg(refresh_due),
      .refresh_row_reg(refresh_row)
   );
   // Accepts a new cycle only while idle, or a same-row cycle in a page.
   // A due refresh holds both off, so a long page cannot starve it.
   assign req_ready = !refresh_due && (state_reg == S_IDLE ||
      (state_reg == S_PAGE && page_open_reg));
   // The data pin comes from an unclocked part, so it is synchronised.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= read_data_out;
         sync2_reg <= sync1_reg;
      end
   end
   // ------------------------------------------------------------
   // Strobe sequencer
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= S_IDLE;
         cnt_reg <= 8'h00;
         write_reg <= 1'b0;
         delayed_reg <= 1'b0;
         last_reg <= 1'b0;
         bank_reg <= {$clog2(BANKS){1'b0}};
         row_reg <= {ADDR_W{1'b0}};
         col_reg <= {ADDR_W{1'b0}};
         data_reg <= 1'b0;
         page_open_reg <= 1'b0;
         refresh_done <= 1'b0;
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 1'b0;
         mem_addr_reg <= {ADDR_W{1'b0}};
         row_strobe_n_reg <= 1'b1;
         column_strobe_n_reg <= {BANKS{1'b1}};
         write_enable_n_reg <= 1'b1;
         write_data_in_reg <= 1'b0;
      end else begin
         refresh_done <= 1'b0;
         rd_valid_reg <= 1'b0;
         cnt_reg <= cnt_reg + 8'h01;
         case (state_reg)
            S_IDLE: begin
               cnt_reg <= 8'h00;
               if (refresh_due) begin
                  // The refresh row settles one cycle before the strobe.
                  mem_addr_reg <= refresh_row;
                  state_reg <= S_REF;
               end else if (req_valid) begin
                  write_reg <= req_write;
                  delayed_reg <= req_delayed;
                  last_reg <= req_page_last;
                  bank_reg <= req_bank;
                  row_reg <= req_addr[2*ADDR_W-1:ADDR_W];
                  col_reg <= req_addr[ADDR_W-1:0];
                  data_reg <= req_wdata;
                  mem_addr_reg <= req_addr[2*ADDR_W-1:ADDR_W];
                  state_reg <= S_ROW;
               end
            end
            S_ROW: begin
               // Address settles one cycle before the row strobe falls.
               row_strobe_n_reg <= 1'b0;
               cnt_reg <= 8'h00;
               state_reg <= S_COL;
            end
            S_COL: begin
               if (cnt_reg == HOLD_C) begin
                  mem_addr_reg <= col_reg;
               end
               if (cnt_reg == RCD_C) begin
                  // Early write drops write enable and data first.
                  if (write_reg && !delayed_reg) begin
                     write_enable_n_reg <= 1'b0;
                  end
                  write_data_in_reg <= data_reg;
               end
               if (cnt_reg == RCD_C + 8'h01) begin
                  column_strobe_n_reg <= col_sel_n(bank_reg);
                  cnt_reg <= 8'h00;
                  page_open_reg <= 1'b1;
                  state_reg <= S_ACC;
               end
            end
            S_ACC: begin
               // Delayed write drops write enable after the column strobe.
               if (write_reg && delayed_reg && cnt_reg == ACC_C_C) begin
                  write_enable_n_reg <= 1'b0;
               end
               // Wait the longer access; synchroniser adds two cycles.
               if (!write_reg && cnt_reg == ACC_R_C + 8'h02) begin
                  rd_valid_reg <= 1'b1;
                  rd_data_reg <= sync2_reg;
               end
               if (cnt_reg == ACC_R_C + WR_C + 8'h02) begin
                  write_enable_n_reg <= 1'b1;
                  column_strobe_n_reg <= {BANKS{1'b1}};
                  cnt_reg <= 8'h00;
                  state_reg <= last_reg ? S_PRE : S_PAGE;
               end
            end
            S_PAGE: begin
               // Row strobe stays low; next column of the same row.
               if (refresh_due) begin
                  cnt_reg <= 8'h00;
                  state_reg <= S_PRE;
               end else if (req_valid) begin
                  write_reg <= req_write;
                  delayed_reg <= req_delayed;
                  last_reg <= req_page_last;
                  bank_reg <= req_bank;
                  col_reg <= req_addr[ADDR_W-1:0];
                  mem_addr_reg <= req_addr[ADDR_W-1:0];
                  data_reg <= req_wdata;
                  cnt_reg <= RCD_C - 8'h01;
                  state_reg <= S_COL;
               end
            end
            S_PRE: begin
               row_strobe_n_reg <= 1'b1;
               page_open_reg <= 1'b0;
               if (cnt_reg == PRE_C) begin
                  state_reg <= S_IDLE;
               end
            end
            S_REF: begin
               // Row-strobe-only refresh; column strobes stay high.
               if (cnt_reg == ACC_R_C) begin
                  row_strobe_n_reg <= 1'b1;
                  refresh_done <= 1'b1;
                  cnt_reg <= 8'h00;
                  state_reg <= S_PRE;
               end else begin
                  row_strobe_n_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule // dram_strobe_ctrl

// File: bench/dram_cell_model.sv
// Behavioural model of one 16K x 1 multiplexed-address dynamic RAM.
`timescale 1ns/1ps
module dram_cell_model (
   input wire row_strobe_n,
   input wire column_strobe_n,
   input wire write_enable_n,
   input wire [6:0] addr,
   input wire din,
   output reg dout,
   output reg oe
);
reg mem [0:16383];
reg [6:0] row = 0, col = 0;
realtime ras_t = 0;
initial oe = 1'b0;
initial dout = 1'b0;
// A row-only cycle refreshes and leaves the output as it was.
always @(negedge row_strobe_n) begin
   row = addr;
   ras_t = $realtime;
end
always @(negedge column_strobe_n) if (!row_strobe_n) begin
   col = addr;
   oe = 1'b0;
   if (!write_enable_n) mem[{row, col}] = din;
   else begin
      #165;
      if (ras_t + 250 > $realtime) #(ras_t + 250 - $realtime);
      if (!column_strobe_n) begin
         dout = mem[{row, col}];
         oe = 1'b1;
      end
   end
end
always @(negedge write_enable_n)
   if (!row_strobe_n && !column_strobe_n) mem[{row, col}] = din;
always @(posedge column_strobe_n) oe = 1'b0;
endmodule // dram_cell_model

// File: bench/dram_strobe_props.sv
// Pin sequencing checker for the dynamic RAM strobe controller.
`timescale 1ns/1ps
module dram_strobe_props #(
   parameter ADDR_W = 7,
   parameter BANKS = 2,
   parameter REFRESH_STEP = 50
) (
   input wire mclk,
   input wire rst,
   input wire rd_valid_reg,
   input wire [ADDR_W-1:0] mem_addr_reg,
   input wire row_strobe_n_reg,
   input wire [BANKS-1:0] column_strobe_n_reg,
   input wire write_enable_n_reg,
   input wire write_data_in_reg
);
wire cas_idle = &column_strobe_n_reg;
reg [15:0] cas_low_reg, ras_high_reg;
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      cas_low_reg <= 16'h0000;
      ras_high_reg <= 16'h0000;
   end else begin
      cas_low_reg <= cas_idle ? 16'h0000 : cas_low_reg + 16'h0001;
      ras_high_reg <= row_strobe_n_reg ? ras_high_reg + 16'h0001 : 16'h0000;
   end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (rst);
property p_cas_ras; $fell(cas_idle) |-> !row_strobe_n_reg; endproperty
a_cas_ras: assert property (p_cas_ras)
   else $error("column strobe without row strobe");
property p_row_hold;
   $fell(row_strobe_n_reg) |=> $stable(mem_addr_reg) [*3];
endproperty
a_row_hold: assert property (p_row_hold)
   else $error("row address not held");
property p_col_addr; $fell(cas_idle) |-> $stable(mem_addr_reg); endproperty
a_col_addr: assert property (p_col_addr)
   else $error("address moving at column strobe");
property p_one_bank; $onehot0(~column_strobe_n_reg); endproperty
a_one_bank: assert property (p_one_bank)
   else $error("two column strobes low");
property p_we_ras; !write_enable_n_reg |-> !row_strobe_n_reg; endproperty
a_we_ras: assert property (p_we_ras)
   else $error("write enable outside row cycle");
property p_early_data;
   $fell(cas_idle) && !write_enable_n_reg |-> $stable(write_data_in_reg) [*3];
endproperty
a_early_data: assert property (p_early_data)
   else $error("write data moved at column strobe");
property p_read_access;
   rd_valid_reg |-> !cas_idle && cas_low_reg >= 16'd21;
endproperty
a_read_access: assert property (p_read_access)
   else $error("read taken before access time");
property p_refresh_gap;
   row_strobe_n_reg |-> ras_high_reg < REFRESH_STEP + 64;
endproperty
a_refresh_gap: assert property (p_refresh_gap)
   else $error("refresh overdue");
c_read: cover property (rd_valid_reg);
c_delayed: cover property ($fell(write_enable_n_reg) && !cas_idle);
c_refresh: cover property ($rose(row_strobe_n_reg) && cas_idle);
endmodule // dram_strobe_props
bind dram_strobe_ctrl dram_strobe_props #(.ADDR_W(ADDR_W), .BANKS(BANKS),
   .REFRESH_STEP(REFRESH_STEP)) i_props (.mclk(mclk), .rst(rst),
   .rd_valid_reg(rd_valid_reg), .mem_addr_reg(mem_addr_reg),
   .row_strobe_n_reg(row_strobe_n_reg),
   .column_strobe_n_reg(column_strobe_n_reg),
   .write_enable_n_reg(write_enable_n_reg),
   .write_data_in_reg(write_data_in_reg));

// File: bench/tb.sv
// Self-checking bench for the dynamic RAM strobe controller.
`timescale 1ns/1ps
module tb;
reg mclk = 0, rst = 1, req_valid = 0, req_write = 0, req_delayed = 0;
reg req_page_last = 0, req_bank = 0, req_wdata = 0, flip = 0;
reg [13:0] req_addr = 0;
reg [6:0] cur_row = 0, prev_row = 0;
wire req_ready, rd_valid_reg, rd_data_reg, row_strobe_n_reg;
wire write_enable_n_reg, write_data_in_reg;
wire [6:0] mem_addr_reg;
wire [1:0] column_strobe_n_reg, dout, oe;
integer n_errors = 0, comparisons = 0, ras_falls = 0;
// A released data line toggles so a stale level can never pass.
wire read_data_out = oe[0] ? dout[0] : oe[1] ? dout[1] : flip;
always #4 mclk = ~mclk;
always @(posedge mclk) flip <= ~flip;
always @(negedge row_strobe_n_reg) begin
   ras_falls = ras_falls + 1;
   prev_row = cur_row;
   cur_row = mem_addr_reg;
end
dram_strobe_ctrl #(.ADDR_W(7), .BANKS(2), .REFRESH_STEP(600)) i_dut (
   .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
   .req_delayed(req_delayed), .req_page_last(req_page_last),
   .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
   .req_ready(req_ready), .rd_valid_reg(rd_valid_reg),
   .rd_data_reg(rd_data_reg), .mem_addr_reg(mem_addr_reg),
   .row_strobe_n_reg(row_strobe_n_reg),
   .column_strobe_n_reg(column_strobe_n_reg),
   .write_enable_n_reg(write_enable_n_reg),
   .write_data_in_reg(write_data_in_reg), .read_data_out(read_data_out));
dram_cell_model i_dev0 (.row_strobe_n(row_strobe_n_reg),
   .column_strobe_n(column_strobe_n_reg[0]), .addr(mem_addr_reg),
   .write_enable_n(write_enable_n_reg), .din(write_data_in_reg),
   .dout(dout[0]), .oe(oe[0]));
dram_cell_model i_dev1 (.row_strobe_n(row_strobe_n_reg),
   .column_strobe_n(column_strobe_n_reg[1]), .addr(mem_addr_reg),
   .write_enable_n(write_enable_n_reg), .din(write_data_in_reg),
   .dout(dout[1]), .oe(oe[1]));
// ---------------------------------------------------------------
// Shared tasks
// ---------------------------------------------------------------
task check(input logic [13:0] seen, input logic [13:0] exp, input string s);
   comparisons = comparisons + 1;
   if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected %s: expected %h, seen %h", s, exp, seen);
   end
endtask
task report_and_stop;
   if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish;
endtask
task tick;
   @(posedge mclk);
   #1;
endtask
// Waits for ready (0), read data (1) or bank 0 column strobe (2).
task await(input integer k);
   integer i;
   for (i = 0; i < 900; i = i + 1) begin
      if (k == 0 ? req_ready === 1'b1 : k == 1 ? rd_valid_reg === 1'b1 :
         column_strobe_n_reg[0] === 1'b0) break;
      tick;
   end
   if (i == 900) begin
      check(0, 1, "wait");
      report_and_stop;
   end
endtask
task issue(input w, d, l, b, input [13:0] a, input wd);
   {req_valid, req_write, req_delayed, req_page_last, req_bank, req_addr,
      req_wdata} = {1'b1, w, d, l, b, a, wd};
   await(0);
   tick;
   req_valid = 1'b0;
   tick;
endtask
task read_chk(input b, l, input [13:0] a, input exp);
   issue(0, 0, l, b, a, 0);
   await(1);
   check(rd_data_reg, exp, "read bit");
endtask
// ---------------------------------------------------------------
// Scenarios
// ---------------------------------------------------------------
task t_refresh;
   integer start;
   start = ras_falls;
   repeat (1300) tick;
   check(ras_falls - start, 2, "refresh count");
   check(cur_row, 7'(prev_row + 7'h01), "refresh row");
endtask
task t_page;
   integer start;
   start = ras_falls;
   issue(1, 0, 0, 0, 14'h02ff, 1);
   issue(1, 0, 0, 1, 14'h02ff, 0);
   read_chk(0, 0, 14'h02ff, 1);
   read_chk(1, 1, 14'h02ff, 0);
   check(ras_falls - start, 1, "page row strobes");
endtask
task t_early;
   issue(1, 0, 1, 0, 14'h3f80, 1);
   await(2);
   repeat (30) tick;
   check(oe[0], 0, "early write output");
   issue(1, 0, 1, 0, 14'h007f, 0);
   read_chk(0, 1, 14'h3f80, 1);
   read_chk(0, 1, 14'h007f, 0);
endtask
task t_delayed;
   issue(1, 1, 1, 0, 14'h3f80, 0);
   await(2);
   repeat (26) tick;
   check(oe[0], 1, "delayed write output");
   read_chk(0, 1, 14'h3f80, 0);
endtask
initial begin
   repeat (2) @(posedge mclk);
   #1;
   rst = 1'b0;
   t_refresh;
   t_page;
   t_early;
   t_delayed;
   report_and_stop;
end
endmodule // tb
